// file: vjel_loader.sv
// Purpose: Discrete-style VME to JTAG emergency loader with mode switch
// Assumes: VME pins are asynchronous; A24 decode uses the five base bits
// Notes:   Needs no help from the main FPGA; fed from the on-board clock
`timescale 1ns/1ns
`default_nettype none
`include "vjel_defines.svh"

module vjel_loader #(
  parameter int SETUP_CYC = `VJEL_SETUP_CYC,
  parameter int HIGH_CYC  = `VJEL_TCK_HIGH_CYC
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rstn_i,
  // VME slave pins
  input  wire logic                 vme_as_n_i,
  input  wire logic                 vme_ds_n_i,
  input  wire vjel_pkg::vjel_vme_s  vme_bus_i,
  input  wire logic [4:0]           vme_ga_n_i,
  input  wire logic                 vme64x_i,
  output logic                      vme_dtack_n_o,
  output logic                      vme_dtack_oe_n_o,
  // Mode switch and overrides
  input  wire logic [8:1]           mode_sw_i,
  input  wire logic                 clk_sel_ovr_en_i,
  input  wire logic                 clk_sel_ovr_i,
  input  wire logic                 image_fallback_boot_i,
  // Board controls
  output logic                      clk_onboard_sel_o,
  output logic                      boot_fallback_select_o,
  output logic [4:0]                a24_base_o,
  output logic [1:0]                am_class_o,
  // JTAG to PROM chain
  output vjel_pkg::vjel_jtag_s      jtag_o,
  output logic                      write_seen_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: everything from the backplane crosses two flops

  localparam int NSYNC = 2 + $bits(vjel_pkg::vjel_vme_s) + 5 + 1 + 8 + 3;

  logic [NSYNC-1:0]    pins_raw;
  logic [NSYNC-1:0]    pins_s;
  logic                as_s;
  logic                ds_s;
  logic                as_n_s;
  logic                ds_n_s;
  vjel_pkg::vjel_vme_s bus_s;
  logic [4:0]          ga_n_s;
  logic                vme64x_s;
  logic [8:1]          sw_s;
  logic                ovr_en_s;
  logic                ovr_s;
  logic                fallback_s;

  // Strobes cross inverted so the flops' reset value reads as idle
  assign pins_raw = {~vme_as_n_i, ~vme_ds_n_i, vme_bus_i, vme_ga_n_i,
                     vme64x_i, mode_sw_i, clk_sel_ovr_en_i, clk_sel_ovr_i,
                     image_fallback_boot_i};
  assign {as_s, ds_s, bus_s, ga_n_s, vme64x_s, sw_s, ovr_en_s, ovr_s,
          fallback_s} = pins_s;
  assign as_n_s = ~as_s;
  assign ds_n_s = ~ds_s;

  vjel_sync #(
    .WIDTH (NSYNC)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (pins_raw),
    .sync_o    (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode switch

  logic [4:0] base_d;
  logic [4:0] base_sw;

  // Switch bit 1 carries A19, bit 5 carries A23
  for (genvar g = 0; g < 5; g++) begin : g_base_sw
    assign base_sw[g] = sw_s[g+1];
  end

  always_comb begin
    if (!sw_s[`VJEL_SW_BASE_BIT]) begin
      base_d = vme64x_s ? ~ga_n_s : 5'h0;
    end else begin
      base_d = base_sw;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a24_base_o <= 5'h0;
    end else begin
      a24_base_o <= base_d;
    end
  end

  // Software can override the switch through an FPGA-driven pin
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_onboard_sel_o <= 1'b1;
    end else begin
      clk_onboard_sel_o <= ovr_en_s ? ovr_s : sw_s[`VJEL_SW_CLK_BIT];
    end
  end

  // Fallback only acts when image 1 was requested
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_fallback_select_o <= 1'b0;
    end else begin
      boot_fallback_select_o <= sw_s[`VJEL_SW_IMG_BIT] & ~fallback_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address modifier classes and decode

  vjel_pkg::vjel_amc_e amc;
  logic                adr_hit;
  logic                emerg_hit;

  always_comb begin
    unique case (bus_s.am)
      `VJEL_AM_USR0, `VJEL_AM_USR1, `VJEL_AM_USR2, `VJEL_AM_USR3: begin
        amc = vjel_pkg::VJEL_AMC_EMERG;
      end
      6'h39, 6'h3A, 6'h3D, 6'h3E: begin
        amc = vjel_pkg::VJEL_AMC_A24;
      end
      `VJEL_AM_A32_BLT, `VJEL_AM_A32_MBLT, 6'h0F, 6'h0C: begin
        amc = vjel_pkg::VJEL_AMC_A32BLK;
      end
      default: begin
        amc = vjel_pkg::VJEL_AMC_NONE;
      end
    endcase
  end

  // A[31:24] never looked at
  assign adr_hit = (bus_s.addr[23:19] == a24_base_o)
                && (bus_s.addr[18:2] == `VJEL_ADR_PATTERN);
  assign emerg_hit = (amc == vjel_pkg::VJEL_AMC_EMERG) && adr_hit
                  && !bus_s.write_n && !bus_s.lword_n;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      am_class_o <= 2'h0;
    end else begin
      am_class_o <= as_n_s ? 2'h0 : 2'(amc);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // JTAG sequencer: settle TMS/TDI, pulse TCK once, then acknowledge

  localparam logic [7:0] SETUP_N = 8'(SETUP_CYC);
  localparam logic [7:0] HIGH_N  = 8'(HIGH_CYC);

  vjel_pkg::vjel_state_e state_q;
  logic [7:0]            cnt_q;
  logic                  strobe;

  assign strobe = !as_n_s && !ds_n_s;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= vjel_pkg::VJEL_IDLE;
      cnt_q   <= 8'h00;
    end else begin
      unique case (state_q)
        vjel_pkg::VJEL_IDLE: begin
          cnt_q <= 8'h00;
          if (strobe && emerg_hit) begin
            state_q <= vjel_pkg::VJEL_SETUP;
          end
        end
        vjel_pkg::VJEL_SETUP: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q + 8'h01 >= SETUP_N) begin
            state_q <= vjel_pkg::VJEL_PULSE;
            cnt_q   <= 8'h00;
          end
        end
        vjel_pkg::VJEL_PULSE: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q + 8'h01 >= HIGH_N) begin
            state_q <= vjel_pkg::VJEL_ACK;
          end
        end
        vjel_pkg::VJEL_ACK: begin
          state_q <= vjel_pkg::VJEL_WAIT_REL;
        end
        vjel_pkg::VJEL_WAIT_REL: begin
          // One pulse per cycle: wait for the master to drop its data strobe
          if (ds_n_s) begin
            state_q <= vjel_pkg::VJEL_IDLE;
          end
        end
        // Unused codes fall back to idle rather than lock up
        default: begin
          state_q <= vjel_pkg::VJEL_IDLE;
        end
      endcase
    end
  end

  // Levels change only on an accepted write and then hold
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      jtag_o <= '0;
    end else begin
      if (state_q == vjel_pkg::VJEL_IDLE && strobe && emerg_hit) begin
        jtag_o.tms <= bus_s.data[`VJEL_TMS_BIT];
        jtag_o.tdi <= bus_s.data[`VJEL_TDI_BIT];
      end
      jtag_o.tck <= (state_q == vjel_pkg::VJEL_PULSE
                     && cnt_q + 8'h01 < HIGH_N)
                 || (state_q == vjel_pkg::VJEL_SETUP
                     && cnt_q + 8'h01 >= SETUP_N);
    end
  end

  // DTACK is open-drain: enable low while pulling the line
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vme_dtack_n_o    <= 1'b1;
      vme_dtack_oe_n_o <= 1'b1;
      write_seen_o     <= 1'b0;
    end else begin
      vme_dtack_n_o    <= !(state_q == vjel_pkg::VJEL_ACK
                         || (state_q == vjel_pkg::VJEL_WAIT_REL && !ds_n_s));
      vme_dtack_oe_n_o <= !(state_q == vjel_pkg::VJEL_ACK
                         || (state_q == vjel_pkg::VJEL_WAIT_REL && !ds_n_s));
      write_seen_o     <= (state_q == vjel_pkg::VJEL_ACK);
    end
  end

endmodule : vjel_loader

`default_nettype wire

// file: vjel_defines.svh
// Purpose: Constants for the VME-to-JTAG emergency loader
// Assumes: 125 MHz system clock; VME strobes sampled as asynchronous pins
// Notes:   Offsets, codes and counts live here; types live in the package
`ifndef VJEL_DEFINES_SVH
`define VJEL_DEFINES_SVH

`define VJEL_AM_USR0      6'h19
`define VJEL_AM_USR1      6'h1A
`define VJEL_AM_USR2      6'h1D
`define VJEL_AM_USR3      6'h1E
`define VJEL_AM_A24_MASK  6'h38
`define VJEL_AM_A24_STD   6'h38
`define VJEL_AM_A32_MASK  6'h38
`define VJEL_AM_A32_STD   6'h08
`define VJEL_AM_A32_BLT   6'h0B
`define VJEL_AM_A32_MBLT  6'h08
`define VJEL_ADR_PATTERN  17'h0_3FFF
`define VJEL_TDI_BIT      1
`define VJEL_TMS_BIT      0
`define VJEL_SW_CLK_BIT   8
`define VJEL_SW_BASE_BIT  7
`define VJEL_SW_IMG_BIT   6
`define VJEL_SETUP_NS     16
`define VJEL_TCK_HIGH_NS  40
`define VJEL_CLK_MHZ      125
`define VJEL_SETUP_CYC    (((`VJEL_SETUP_NS * `VJEL_CLK_MHZ) + 999) / 1000)
`define VJEL_TCK_HIGH_CYC (((`VJEL_TCK_HIGH_NS * `VJEL_CLK_MHZ) + 999) / 1000)

`endif

// file: vjel_pkg.sv
// Purpose: Types shared by the emergency loader files
// Assumes: Nothing beyond the defines header
// Notes:   Holds only types
package vjel_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [5:0]  am;
    logic [31:0] data;
    logic        write_n;
    logic        lword_n;
  } vjel_vme_s;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } vjel_jtag_s;

  typedef enum logic [1:0] {
    VJEL_AMC_NONE,
    VJEL_AMC_EMERG,
    VJEL_AMC_A24,
    VJEL_AMC_A32BLK
  } vjel_amc_e;

  typedef enum logic [2:0] {
    VJEL_IDLE,
    VJEL_SETUP,
    VJEL_PULSE,
    VJEL_ACK,
    VJEL_WAIT_REL
  } vjel_state_e;

endpackage : vjel_pkg

// file: vjel_sync.sv
// Purpose: Two-stage synchroniser for a vector of asynchronous pins
// Assumes: Inputs are quasi-static once the strobe that qualifies them is seen
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module vjel_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  // Pins
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : vjel_sync

`default_nettype wire

// file: vjel_monitor.sv
// Purpose: Port assertions for the loader
// Assumes: One clock; reset disables checks
// Notes:   Bound from the bench top file
`timescale 1ns/1ns
`default_nettype none
module vjel_monitor #(
  parameter int HIGH_CYC = 5
) (
  // Clock, reset
  input wire logic                 sys_clk_i,
  input wire logic                 rstn_i,
  // VME side
  input wire logic                 vme_as_n_i,
  input wire logic                 vme_ds_n_i,
  input wire vjel_pkg::vjel_vme_s  vme_bus_i,
  input wire logic                 vme_dtack_n_o,
  input wire logic                 vme_dtack_oe_n_o,
  input wire logic [1:0]           am_class_o,
  // JTAG side
  input wire vjel_pkg::vjel_jtag_s jtag_o,
  input wire logic                 write_seen_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  int   hi_q;
  logic emerg;
  assign emerg = vme_bus_i.am inside {6'h19, 6'h1a, 6'h1d, 6'h1e};
  // Cheaper than a long repetition
  always_ff @(posedge sys_clk_i or negedge rstn_i)
    if (!rstn_i)
      hi_q <= 0;
    else
      hi_q <= jtag_o.tck ? hi_q + 1 : 0;
  ////////////////////////////////////////////////////////////////////////
  tck_setup_a: assert property ($rose(jtag_o.tck) |->
    $stable({jtag_o.tms, jtag_o.tdi})) else $error("tck setup");
  tck_width_a: assert property ($fell(jtag_o.tck) |->
    hi_q == HIGH_CYC) else $error("tck width");
  seen_pulse_a: assert property (write_seen_o |=>
    !write_seen_o) else $error("seen pulse");
  seen_after_a: assert property ($rose(jtag_o.tck) |->
    ##[1:12] write_seen_o) else $error("no seen");
  dtack_cause_a: assert property ($fell(vme_dtack_n_o) |-> emerg &&
    !vme_bus_i.write_n && !vme_bus_i.lword_n) else $error("dtack");
  jtag_src_a: assert property ($changed({jtag_o.tms, jtag_o.tdi}) |->
    vme_bus_i.data[1:0] == {jtag_o.tdi, jtag_o.tms}) else $error("src");
  dtack_rel_a: assert property ($rose(vme_ds_n_i) |->
    ##[1:5] vme_dtack_n_o) else $error("dtack held");
  class_idle_a: assert property (vme_as_n_i [*5] |->
    am_class_o == 2'd0) else $error("class idle");
  dtack_enable_a: assert property (vme_dtack_oe_n_o == vme_dtack_n_o)
    else $error("dtack enable");
  cover property (write_seen_o);
  cover property (am_class_o == 2'd2);
  cover property (am_class_o == 2'd3);
endmodule : vjel_monitor
`default_nettype wire

// file: vjel_host.sv
// Purpose: VME master model, single cycles
// Assumes: Lines move just after rising edges
// Notes:   Gives up after 40 cycles without DTACK
`timescale 1ns/1ns
`default_nettype none
module vjel_host (
  // Clock and answer
  input  wire logic           sys_clk_i,
  input  wire logic           dtack_n_i,
  input  wire logic [1:0]     class_i,
  // Master pins
  output logic                as_n_o,
  output logic                ds_n_o,
  output vjel_pkg::vjel_vme_s bus_o
);
  logic       acked;
  logic [1:0] cls;
  initial begin
    as_n_o = 1'b1;
    ds_n_o = 1'b1;
    bus_o  = '0;
  end
  task automatic cycle(input vjel_pkg::vjel_vme_s b);
    int n;
    n = 0;
    acked = 1'b0;
    bus_o <= b;
    @(posedge sys_clk_i);
    as_n_o <= 1'b0;
    ds_n_o <= 1'b0;
    while (!acked && n < 40) begin
      @(posedge sys_clk_i);
      n++;
      acked = !dtack_n_i;
      if (n == 6)
        cls = class_i;
    end
    as_n_o <= 1'b1;
    ds_n_o <= 1'b1;
    // Released lines must not keep the old value
    bus_o  <= ~b;
    repeat (5) @(posedge sys_clk_i);
  endtask : cycle
endmodule : vjel_host
`default_nettype wire

// file: test_vme_jtag_emergency_loader.sv
// Purpose: Random and corner tests of the loader
// Assumes: Host model runs one cycle at a time
// Notes:   Switch bases are random, so a reversed field order shows up
`timescale 1ns/1ns
`default_nettype none
module test_vme_jtag_emergency_loader;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic vme_as_n_i, vme_ds_n_i, vme_dtack_n_o, vme_dtack_oe_n_o;
  logic vme64x_i = 1'b1;
  logic clk_sel_ovr_en_i = 1'b0;
  logic clk_sel_ovr_i = 1'b0;
  logic image_fallback_boot_i = 1'b0;
  logic clk_onboard_sel_o, boot_fallback_select_o, write_seen_o;
  logic [4:0] vme_ga_n_i = 5'h1a;
  logic [4:0] a24_base_o, base, ga, pv;
  logic [8:1] mode_sw_i = 8'h80;
  logic [1:0] am_class_o;
  logic tms = 1'b0;
  logic tdi = 1'b0;
  vjel_pkg::vjel_vme_s  vme_bus_i, v;
  vjel_pkg::vjel_jtag_s jtag_o;
  int mismatches = 0;
  int tests_run = 0;
  int rises = 0;
  int seens = 0;
  logic [5:0] ams [8] = '{6'h19, 6'h1a, 6'h1d, 6'h1e,
                          6'h39, 6'h0b, 6'h2d, 6'h08};
  vjel_loader dut (
    .sys_clk_i              (sys_clk_i),
    .rstn_i                 (rstn_i),
    .vme_as_n_i             (vme_as_n_i),
    .vme_ds_n_i             (vme_ds_n_i),
    .vme_bus_i              (vme_bus_i),
    .vme_ga_n_i             (vme_ga_n_i),
    .vme64x_i               (vme64x_i),
    .vme_dtack_n_o          (vme_dtack_n_o),
    .vme_dtack_oe_n_o       (vme_dtack_oe_n_o),
    .mode_sw_i              (mode_sw_i),
    .clk_sel_ovr_en_i       (clk_sel_ovr_en_i),
    .clk_sel_ovr_i          (clk_sel_ovr_i),
    .image_fallback_boot_i  (image_fallback_boot_i),
    .clk_onboard_sel_o      (clk_onboard_sel_o),
    .boot_fallback_select_o (boot_fallback_select_o),
    .a24_base_o             (a24_base_o),
    .am_class_o             (am_class_o),
    .jtag_o                 (jtag_o),
    .write_seen_o           (write_seen_o)
  );
  vjel_host host (
    .sys_clk_i (sys_clk_i),
    .dtack_n_i (vme_dtack_n_o),
    .class_i   (am_class_o),
    .as_n_o    (vme_as_n_i),
    .ds_n_o    (vme_ds_n_i),
    .bus_o     (vme_bus_i)
  );
  initial forever #4 sys_clk_i = ~sys_clk_i;
  always @(posedge jtag_o.tck) rises++;
  always @(posedge sys_clk_i) if (write_seen_o) seens++;
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [1:0] exp_class(logic [5:0] am);
    case (am)
      6'h19, 6'h1a, 6'h1d, 6'h1e: return 2'd1;
      6'h39, 6'h3a, 6'h3d, 6'h3e: return 2'd2;
      6'h08, 6'h0b, 6'h0c, 6'h0f: return 2'd3;
      default: return 2'd0;
    endcase
  endfunction : exp_class
  task automatic xfer();
    logic ok;
    int   r0;
    int   s0;
    ok = exp_class(v.am) == 2'd1 && !v.write_n && !v.lword_n &&
      v.addr[23:19] == base && v.addr[18:2] == 17'h0_3fff;
    r0 = rises;
    s0 = seens;
    if (ok) begin
      tms = v.data[0];
      tdi = v.data[1];
    end
    host.cycle(v);
    chk(host.acked, ok);
    chk(host.cls, exp_class(v.am));
    chk(rises - r0, ok);
    chk(seens - s0, ok);
    chk({jtag_o.tdi, jtag_o.tms}, {tdi, tms});
  endtask : xfer
  task automatic close_out();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hdfa7_7128));
    repeat (19) @(posedge sys_clk_i);
    chk({vme_dtack_n_o, vme_dtack_oe_n_o, clk_onboard_sel_o, jtag_o,
      boot_fallback_select_o, a24_base_o, am_class_o, write_seen_o},
      {3'b111, 12'h000});
    @(posedge sys_clk_i) rstn_i <= 1'b1;
    // Clock select and image fallback checked over all 32 switch and override combinations before any traffic
    for (int i = 0; i < 32; i++) begin
      @(posedge sys_clk_i);
      mode_sw_i[8] <= i[0];
      clk_sel_ovr_en_i <= i[1];
      clk_sel_ovr_i <= i[2];
      mode_sw_i[6] <= i[3];
      image_fallback_boot_i <= i[4];
      repeat (6) @(posedge sys_clk_i);
      chk(clk_onboard_sel_o, i[1] ? i[2] : i[0]);
      chk(boot_fallback_select_o, i[3] & !i[4]);
    end
    $display("test modes done");
    for (int k = 0; k < 4; k++) begin
      ga = 5'($urandom);
      pv = 5'($urandom);
      vme_ga_n_i <= ga;
      vme64x_i <= k != 1;
      mode_sw_i[7] <= k == 2;
      mode_sw_i[5:1] <= pv;
      base = k == 2 ? pv : k == 1 ? 5'h00 : ~ga;
      repeat (6) @(posedge sys_clk_i);
      chk(a24_base_o, base);
      for (int j = 0; j < 30; j++) begin
        v.am = j < 4 ? ams[j] : ams[$urandom % 8];
        if ($urandom % 8 == 0)
          v.am = 6'($urandom);
        v.addr = {8'($urandom), base, 17'h0_3fff, 2'b00};
        if ($urandom % 6 == 0)
          v.addr[2 + $urandom % 22] ^= 1'b1;
        if (exp_class(v.am) == 2'd2)
          v.addr[15:0] = 16'h0000;
        v.data = $urandom;
        v.write_n = $urandom % 8 == 0;
        v.lword_n = $urandom % 8 == 0;
        xfer();
      end
      $display("test base %0d done", k);
    end
    // Reset in mid-run: levels drop, then writes are taken again
    rstn_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk({jtag_o, vme_dtack_n_o, write_seen_o}, 5'b000_10);
    rstn_i <= 1'b1;
    tms = 1'b0;
    tdi = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    v = '0;
    v.am = 6'h1d;
    v.addr = {8'h00, base, 17'h0_3fff, 2'b00};
    v.data = 32'h0000_0003;
    xfer();
    $display("test reset done");
    close_out();
  end
endmodule : test_vme_jtag_emergency_loader
bind vjel_loader vjel_monitor #(.HIGH_CYC(HIGH_CYC)) mon (
  .sys_clk_i        (sys_clk_i),
  .rstn_i           (rstn_i),
  .vme_as_n_i       (vme_as_n_i),
  .vme_ds_n_i       (vme_ds_n_i),
  .vme_bus_i        (vme_bus_i),
  .vme_dtack_n_o    (vme_dtack_n_o),
  .vme_dtack_oe_n_o (vme_dtack_oe_n_o),
  .am_class_o       (am_class_o),
  .jtag_o           (jtag_o),
  .write_seen_o     (write_seen_o)
);
`default_nettype wire
